//--- logic/ubr_core.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Contract
// R01 - frame characters with start and stop bits
// R02 - parity append on transmit, check on receive
// R03 - two sixteen byte buffers, transmit and receive
// R04 - four selectable receive fill thresholds
// R05 - buffer control bit 3 enables block mode
// R06 - buffers off: single byte ready flags
// R07 - buffers on: receive ready when not empty
// R08 - buffers on: transmit ready when empty
// R09 - block mode: receive ready threshold or timeout
// R10 - block mode: transmit ready unless full
// R11 - ready flags in status bits 5 and 4
// R12 - line status bits 5, 6 show transmitter
// R13 - prescaler divides by 4 or 1
// R14 - sixteen bit divisor makes 16x clock
// R15 - shifters run on the 16x enable
// R16 - divisor must be programmed before use
// R17 - host computes divisor from clock and rate
// R18 - enhanced bit inverts the ready flags
// R19 - divisor low at 0, high at 1
// R20 - divisor bytes reachable only with latch bit
// R21 - baud counter pulses then reloads
module ubr_core
  import ubr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in,
  output logic             serial_out
);
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_SHIFT = 4'b0010, TX_PAR = 4'b0100, TX_STOP = 4'b1000
  } ubr_tx_type;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_DATA = 4'b0010, RX_PAR = 4'b0100, RX_STOP = 4'b1000
  } ubr_rx_type;

  logic [7:0]  ier_ff, lcr_ff, mcr_ff, fcr_ff, spr_ff;
  logic [15:0] div_ff;
  logic        aw_ff, w_ff;
  logic [2:0]  waddr_ff;
  logic [31:0] wdat_ff;
  logic [3:0]  wstb_ff;
  logic        tx_push, rx_pop, rx_push;
  logic [7:0]  tx_rdata;
  logic [9:0]  rx_rdata;
  logic [4:0]  tx_cnt, rx_cnt;
  logic [1:0]  pre_ff;
  logic        pre_tick;
  logic [15:0] baud_ff;
  logic        tick16_ff;
  ubr_tx_type  tx_st_ff;
  ubr_rx_type  rx_st_ff;
  logic [3:0]  tx_sub_ff, rx_sub_ff;
  logic [2:0]  tx_bit_ff, rx_bit_ff;
  logic [7:0]  tx_sh_ff, rx_sh_ff;
  logic        tx_par_ff, rx_par_ff, stop2_ff;
  logic        rx_hunt_ff;
  logic        tx_pop;
  logic        oe_ff;
  logic [9:0]  tmo_ff;
  logic        tmo_flag_ff, rx_ready_ff;
  logic        rx_ready, tx_ready;
  logic [4:0]  trig_lvl;
  logic        fifo_en, blk_en, dlab, do_write, do_read;

  function automatic logic [2:0] reg_index(input logic [31:0] addr);
    return addr[4:2];
  endfunction : reg_index

  function automatic logic [2:0] data_bits(input logic [1:0] wl);
    return 3'(3'd4 + 3'(wl));
  endfunction : data_bits

  assign fifo_en = fcr_ff[FCR_EN_BIT];
  // R05 block mode bit
  assign blk_en  = fifo_en && fcr_ff[FCR_BLK_BIT];
  // R20 latch bit selects divisor
  assign dlab    = lcr_ff[LCR_DLAB_BIT];

  // AXI write: address and data taken in any order, response after both
  assign do_write = aw_ff && w_ff && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0; w_ff <= 1'b0; waddr_ff <= '0; wdat_ff <= '0; wstb_ff <= '0;
      s_axi_awready <= 1'b1; s_axi_wready <= 1'b1; s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= 1'b1; waddr_ff <= reg_index(s_axi_awaddr); s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff <= 1'b1; wdat_ff <= s_axi_wdata; wstb_ff <= s_axi_wstrb; s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_ff <= 1'b0; w_ff <= 1'b0; s_axi_bvalid <= 1'b1; s_axi_bresp <= RESP_OK;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0; s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
      end
    end
  end

  // only byte lane 0 carries register data
  assign tx_push = do_write && wstb_ff[0] && !dlab && waddr_ff == IDX_DATA;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ier_ff <= ZERO8; lcr_ff <= LCR_RST; mcr_ff <= ZERO8; fcr_ff <= ZERO8;
      spr_ff <= ZERO8;
      // R16 no meaningful divisor until software writes it
      div_ff <= DIV_RST;
    end
    else
    begin
      fcr_ff[FCR_RXCLR_BIT] <= 1'b0;
      fcr_ff[FCR_TXCLR_BIT] <= 1'b0;
      if (do_write && wstb_ff[0])
      begin
        case (waddr_ff)
          // R19 divisor bytes at 0 and 1
          IDX_DATA: if (dlab) div_ff[7:0] <= wdat_ff[7:0];
          IDX_IER:
            if (dlab) div_ff[15:8] <= wdat_ff[7:0];
            else ier_ff <= wdat_ff[7:0];
          IDX_ISR: fcr_ff <= wdat_ff[7:0];
          IDX_LCR: lcr_ff <= wdat_ff[7:0];
          IDX_MCR: mcr_ff <= wdat_ff[7:0];
          IDX_SPR: spr_ff <= wdat_ff[7:0];
          default: ;
        endcase
      end
    end
  end

  // AXI read
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign rx_pop  = do_read && !dlab && reg_index(s_axi_araddr) == IDX_DATA;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0; s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OK;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OK;
      s_axi_rdata   <= '0;
      case (reg_index(s_axi_araddr))
        IDX_DATA: s_axi_rdata[7:0] <= dlab ? div_ff[7:0] : rx_rdata[7:0];
        IDX_IER:  s_axi_rdata[7:0] <= dlab ? div_ff[15:8] : ier_ff;
        // R11 ready flags in status bits 5 and 4
        IDX_ISR:
        begin
          // R18 enhanced bit inverts the flags
          s_axi_rdata[ISR_RXR_BIT] <= rx_ready ^ ier_ff[IER_ENH_BIT];
          s_axi_rdata[ISR_TXR_BIT] <= tx_ready ^ ier_ff[IER_ENH_BIT];
        end
        IDX_LCR: s_axi_rdata[7:0] <= lcr_ff;
        IDX_MCR: s_axi_rdata[7:0] <= mcr_ff;
        IDX_LSR:
        begin
          s_axi_rdata[LSR_DR_BIT] <= rx_cnt != '0;
          s_axi_rdata[LSR_OE_BIT] <= oe_ff;
          s_axi_rdata[LSR_PE_BIT] <= (rx_cnt != '0) && rx_rdata[8];
          s_axi_rdata[LSR_FE_BIT] <= (rx_cnt != '0) && rx_rdata[9];
          // R12 transmit buffer empty and transmitter completely empty
          s_axi_rdata[LSR_THRE_BIT] <= tx_cnt == '0;
          s_axi_rdata[LSR_TEMT_BIT] <= tx_cnt == '0 && tx_st_ff == TX_IDLE;
        end
        IDX_SPR: s_axi_rdata[7:0] <= spr_ff;
        default: s_axi_rdata <= '0;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  lsr_order_a: // R12
    assert property (@(posedge aclk) disable iff (!aresetn)
      (do_read && reg_index(s_axi_araddr) == IDX_LSR) ##1 s_axi_rdata[LSR_TEMT_BIT]
      |-> s_axi_rdata[LSR_THRE_BIT])
    else $error("line status shows empty transmitter with holding data");

  // R03 transmit and receive buffers
  ubr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .aclk(aclk), .aresetn(aresetn), .clr(fcr_ff[FCR_TXCLR_BIT]),
    .push(tx_push), .wdata(wdat_ff[7:0]), .pop(tx_pop), .rdata(tx_rdata), .count(tx_cnt));
  ubr_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rxf (
    .aclk(aclk), .aresetn(aresetn), .clr(fcr_ff[FCR_RXCLR_BIT]),
    .push(rx_push), .wdata({!serial_in, lcr_ff[LCR_PEN_BIT] && rx_par_ff, rx_sh_ff}),
    .pop(rx_pop),
    .rdata(rx_rdata), .count(rx_cnt));

  // R13 prescaler by 4 or 1
  assign pre_tick = mcr_ff[MCR_PRE_BIT] ? (pre_ff == 2'(PRESCALE_DIV - 1)) : 1'b1;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_ff <= '0;
    else
      pre_ff <= pre_tick ? 2'b00 : pre_ff + 2'b01;
  end

  // R14 divisor counter gives 16x enable
  // R21 pulse on reaching divisor, then reload
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_ff <= 16'h0001; tick16_ff <= 1'b0;
    end
    else
    begin
      tick16_ff <= 1'b0;
      if (pre_tick)
      begin
        if (baud_ff >= div_ff)
        begin
          baud_ff <= 16'h0001; tick16_ff <= 1'b1;
        end
        else
          baud_ff <= baud_ff + 16'h0001;
      end
    end
  end

  prescale_gap_a: // R13
    assert property (@(posedge aclk) disable iff (!aresetn)
      (tick16_ff && mcr_ff[MCR_PRE_BIT]) ##1 mcr_ff[MCR_PRE_BIT] |-> !tick16_ff)
    else $error("sampling enable too soon under prescale");

  baud_reload_a: // R21
    assert property (@(posedge aclk) disable iff (!aresetn)
      (pre_tick && baud_ff >= div_ff) |=> (tick16_ff && baud_ff == 16'h0001))
    else $error("baud counter did not pulse and reload");

  // transmitter; non-buffer mode uses the same store as a one-byte holder
  assign tx_pop = tick16_ff && tx_st_ff == TX_IDLE && tx_cnt != '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_ff <= TX_IDLE; tx_sub_ff <= '0; tx_bit_ff <= '0; tx_sh_ff <= '0;
      tx_par_ff <= 1'b0; stop2_ff <= 1'b0; serial_out <= 1'b1;
    end
    // R15 shift on 16x enable
    else if (tick16_ff)
    begin
      tx_sub_ff <= tx_sub_ff + 4'h1;
      case (tx_st_ff)
        TX_IDLE:
          if (tx_cnt != '0)
          begin
            // R01 start bit first
            serial_out <= 1'b0; tx_sh_ff <= tx_rdata; tx_sub_ff <= '0;
            tx_bit_ff <= '0; tx_par_ff <= !lcr_ff[LCR_EPS_BIT]; stop2_ff <= 1'b0;
            tx_st_ff <= TX_SHIFT;
          end
        TX_SHIFT:
          if (tx_sub_ff == 4'hF)
          begin
            serial_out <= tx_sh_ff[0];
            tx_par_ff  <= tx_par_ff ^ tx_sh_ff[0];
            tx_sh_ff   <= tx_sh_ff >> 1;
            tx_bit_ff  <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == data_bits(lcr_ff[1:0]))
            begin
              tx_st_ff  <= lcr_ff[LCR_PEN_BIT] ? TX_PAR : TX_STOP;
              tx_bit_ff <= '0;
            end
          end
        // R02 parity bit appended
        TX_PAR:
          if (tx_sub_ff == 4'hF)
          begin
            serial_out <= tx_par_ff; tx_st_ff <= TX_STOP;
          end
        // R01 stop bits close the frame
        TX_STOP:
          if (tx_sub_ff == 4'hF)
          begin
            serial_out <= 1'b1;
            stop2_ff   <= 1'b1;
            // bit counter marks the second stop bit so two-stop frames end
            if (stop2_ff && (!lcr_ff[LCR_STB_BIT] || tx_bit_ff != 3'h0))
              tx_st_ff <= TX_IDLE;
            else if (stop2_ff)
              tx_bit_ff <= 3'h1;
          end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  idle_line_a: // R01
    assert property (@(posedge aclk) disable iff (!aresetn)
      tx_st_ff == TX_IDLE |-> serial_out)
    else $error("transmit line low while idle");

  start_bit_a: // R01
    assert property (@(posedge aclk) disable iff (!aresetn)
      (tx_st_ff == TX_IDLE) ##1 (tx_st_ff == TX_SHIFT) |-> !serial_out)
    else $error("frame did not open with a start bit");

  // receiver, sampling mid-bit
  assign rx_push = tick16_ff && rx_st_ff == RX_STOP && rx_sub_ff == 4'hF;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st_ff <= RX_IDLE; rx_sub_ff <= '0; rx_bit_ff <= '0; rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      rx_hunt_ff <= 1'b0;
    end
    // R15 sample on 16x enable
    else if (tick16_ff)
    begin
      rx_sub_ff <= rx_sub_ff + 4'h1;
      case (rx_st_ff)
        RX_IDLE:
          if (!serial_in)
          begin
            // count from start edge so later samples fall mid-bit
            rx_sub_ff <= 4'(OVERSAMPLE - RX_MID + 1);
            rx_bit_ff <= '0; rx_par_ff <= lcr_ff[LCR_EPS_BIT]; rx_st_ff <= RX_DATA;
            rx_sh_ff <= '0;
            rx_hunt_ff <= 1'b1;
          end
        RX_DATA:
          if (rx_sub_ff == 4'hF)
          begin
            // first sample is mid start bit: a high line was only a glitch
            if (rx_hunt_ff)
            begin
              rx_hunt_ff <= 1'b0;
              if (serial_in)
                rx_st_ff <= RX_IDLE;
            end
            else
            begin
              // new bit enters at the top of the character so short words end lsb aligned
              rx_sh_ff  <= (rx_sh_ff >> 1) | (8'(serial_in) << data_bits(lcr_ff[1:0]));
              rx_par_ff <= rx_par_ff ^ serial_in;
              rx_bit_ff <= rx_bit_ff + 3'h1;
              if (rx_bit_ff == data_bits(lcr_ff[1:0]))
                rx_st_ff <= lcr_ff[LCR_PEN_BIT] ? RX_PAR : RX_STOP;
            end
          end
        // R02 mismatch kept as error tag
        RX_PAR:
          if (rx_sub_ff == 4'hF)
          begin
            rx_par_ff <= rx_par_ff ^ serial_in ^ 1'b1;
            rx_st_ff  <= RX_STOP;
          end
        RX_STOP:
          if (rx_sub_ff == 4'hF)
            rx_st_ff <= RX_IDLE;
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // overrun: sticky until status read, set wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oe_ff <= 1'b0;
    else if (rx_push && rx_cnt == 5'(FIFO_DEPTH))
      oe_ff <= 1'b1;
    else if (do_read && reg_index(s_axi_araddr) == IDX_LSR)
      oe_ff <= 1'b0;
  end

  // timeout: four characters plus twelve bit times without traffic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tmo_ff <= '0; tmo_flag_ff <= 1'b0;
    end
    else if (rx_push || rx_pop || rx_cnt == '0)
    begin
      tmo_ff <= '0; tmo_flag_ff <= 1'b0;
    end
    else if (tick16_ff && !tmo_flag_ff)
    begin
      tmo_ff <= tmo_ff + 10'h001;
      if (tmo_ff == 10'(OVERSAMPLE * (TIMEOUT_CHARS * (7 + 32'(lcr_ff[1:0]))
                                       + TIMEOUT_EXTRA)))
        tmo_flag_ff <= 1'b1;
    end
  end

  // R04 four thresholds: 1, 4, 8, 14
  always_comb
  begin
    case (fcr_ff[FCR_TRIG_LSB +: 2])
      2'b00:   trig_lvl = 5'd1;
      2'b01:   trig_lvl = 5'd4;
      2'b10:   trig_lvl = 5'd8;
      default: trig_lvl = 5'd14;
    endcase
  end

  // R09 set on threshold or timeout, cleared only when empty
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rx_cnt == '0)
      rx_ready_ff <= 1'b0;
    else if (rx_cnt >= trig_lvl || tmo_flag_ff)
      rx_ready_ff <= 1'b1;
  end

  trig_set_a: // R04
    assert property (@(posedge aclk) disable iff (!aresetn)
      rx_cnt >= trig_lvl |=> rx_ready_ff)
    else $error("receive ready not set at threshold");

  ready_hold_a: // R09
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rx_ready_ff && rx_cnt != 5'd0) |=> rx_ready_ff)
    else $error("receive ready dropped before buffer empty");

  ready_clear_a: // R09
    assert property (@(posedge aclk) disable iff (!aresetn)
      rx_cnt == 5'd0 |=> !rx_ready_ff)
    else $error("receive ready held with empty buffer");

  // R06 R07 non-block ready flags
  assign rx_ready = blk_en ? rx_ready_ff : (rx_cnt != '0);
  // R10 block mode: room for one more byte
  // R08 transmit ready only when empty
  assign tx_ready = blk_en ? (tx_cnt != 5'(FIFO_DEPTH)) : (tx_cnt == '0);
endmodule : ubr_core

//--- logic/ubr_fifo.sv
`timescale 1ns/1ps
module ubr_fifo
  import ubr_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     clr,
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         rdata,
  output logic      [$clog2(DEPTH):0]   count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  logic             do_push;
  logic             do_pop;

  // a push into a full buffer is dropped; the caller flags an overrun for the receive buffer only
  assign do_push = push && (cnt_ff != (AW+1)'(DEPTH));
  assign do_pop  = pop && (cnt_ff != '0);
  assign rdata   = mem[rp_ff];
  assign count   = cnt_ff;

  always_ff @(posedge aclk)
  begin
    if (do_push)
      mem[wp_ff] <= wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clr)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (do_push)
        wp_ff <= wp_ff + AW'(1);
      if (do_pop)
        rp_ff <= rp_ff + AW'(1);
      cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : ubr_fifo

//--- logic/ubr_pkg.sv
package ubr_pkg;
  // register indices (byte address = 4 * index)
  localparam logic [2:0] IDX_DATA  = 3'h0;
  localparam logic [2:0] IDX_IER   = 3'h1;
  localparam logic [2:0] IDX_ISR   = 3'h2;
  localparam logic [2:0] IDX_LCR   = 3'h3;
  localparam logic [2:0] IDX_MCR   = 3'h4;
  localparam logic [2:0] IDX_LSR   = 3'h5;
  localparam logic [2:0] IDX_MSR   = 3'h6;
  localparam logic [2:0] IDX_SPR   = 3'h7;
  // field positions
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXCLR_BIT = 1;
  localparam int FCR_TXCLR_BIT = 2;
  localparam int FCR_BLK_BIT   = 3;
  localparam int FCR_TRIG_LSB  = 6;
  localparam int IER_ENH_BIT   = 5;
  localparam int LCR_DLAB_BIT  = 7;
  localparam int LCR_PEN_BIT   = 3;
  localparam int LCR_EPS_BIT   = 4;
  localparam int LCR_STB_BIT   = 2;
  localparam int MCR_PRE_BIT   = 7;
  localparam int ISR_TXR_BIT   = 4;
  localparam int ISR_RXR_BIT   = 5;
  localparam int LSR_DR_BIT    = 0;
  localparam int LSR_OE_BIT    = 1;
  localparam int LSR_PE_BIT    = 2;
  localparam int LSR_FE_BIT    = 3;
  localparam int LSR_THRE_BIT  = 5;
  localparam int LSR_TEMT_BIT  = 6;
  // reset values, response codes and fixed constants
  localparam logic [7:0]  LCR_RST  = 8'h03;
  localparam logic [7:0]  ZERO8    = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [1:0]  RESP_OK  = 2'b00;
  localparam logic [1:0]  RESP_ERR = 2'b10;
  localparam int PRESCALE_DIV = 4;
  localparam int OVERSAMPLE   = 16;
  localparam int RX_MID       = 8;
  localparam int FIFO_DEPTH   = 16;
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_EXTRA = 12;
endpackage : ubr_pkg

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ubr_pkg::*;
  logic        aclk, aresetn, sin, sout;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          fails      = 0;
  int          num_checks = 0;

  ubr_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .serial_in(sin), .serial_out(sout));
  ubr_line_partner partner (.aclk(aclk), .line_rx(sout), .line_tx(sin));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // bready is held high, so the response is taken at the edge it shows
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic       got;
    logic [1:0] r;
    awaddr  <= {27'h0, i, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
      r = bresp;
    end
    chk("write resp", {6'h0, r}, {6'h0, RESP_OK});
  endtask : wr

  task automatic rd(input logic [2:0] i, output logic [7:0] d);
    logic       got;
    logic [1:0] r;
    araddr  <= {27'h0, i, 2'b00};
    arvalid <= 1'b1;
    got = 1'b0;
    while (!got)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      got = rvalid;
      d = rdata[7:0];
      r = rresp;
    end
    chk("read resp", {6'h0, r}, {6'h0, RESP_OK});
  endtask : rd

  task automatic rc(input string nm, input logic [2:0] i, input logic [7:0] m,
                    input logic [7:0] exp);
    logic [7:0] d;
    rd(i, d);
    chk(nm, d & m, exp);
  endtask : rc

  task automatic tx_chk(input logic [7:0] b);
    logic [7:0] d;
    for (int k = 0; k < 20000 && partner.rx_q.size() == 0; k++) @(posedge aclk);
    d = (partner.rx_q.size() > 0) ? partner.rx_q.pop_front() : 8'hxx;
    chk("serial byte", d, b);
  endtask : tx_chk

  // divisor = clock / prescale / (16 * rate)
  task automatic set_baud(input logic pre, input logic [7:0] dv);
    wr(IDX_MCR, {pre, 7'h0});
    wr(IDX_LCR, 8'h9B);
    wr(IDX_DATA, dv);
    wr(IDX_IER, 8'h00);
    wr(IDX_LCR, 8'h1B);
    partner.bit_clks = (pre ? PRESCALE_DIV : 1) * dv * OVERSAMPLE;
  endtask : set_baud

  task automatic t_reset();
    rc("line ctrl", IDX_LCR, 8'hFF, LCR_RST);
    rc("ready bits", IDX_ISR, 8'h30, 8'h10);
    rc("tx empty", IDX_LSR, 8'h60, 8'h60);
  endtask : t_reset

  task automatic t_baud();
    set_baud(1'b0, 8'h02);
    wr(IDX_IER, 8'h20);
    wr(IDX_LCR, 8'h9B);
    rc("div low", IDX_DATA, 8'hFF, 8'h02);
    rc("div high", IDX_IER, 8'hFF, 8'h00);
    wr(IDX_LCR, 8'h1B);
    rc("enh bit", IDX_IER, 8'h20, 8'h20);
    wr(IDX_IER, 8'h00);
    wr(IDX_DATA, 8'hA5);
    tx_chk(8'hA5);
    set_baud(1'b1, 8'h01);
    wr(IDX_DATA, 8'h3C);
    tx_chk(8'h3C);
    set_baud(1'b0, 8'h02);
  endtask : t_baud

  task automatic t_fifo();
    wr(IDX_ISR, 8'h07);
    wr(IDX_DATA, 8'h11);
    wr(IDX_DATA, 8'h22);
    wr(IDX_DATA, 8'h33);
    rc("tx busy", IDX_ISR, 8'h30, 8'h00);
    rc("tx busy lsr", IDX_LSR, 8'h60, 8'h00);
    tx_chk(8'h11);
    tx_chk(8'h22);
    tx_chk(8'h33);
    repeat (partner.bit_clks) @(posedge aclk);
    rc("tx idle", IDX_ISR, 8'h30, 8'h10);
    rc("tx idle lsr", IDX_LSR, 8'h60, 8'h60);
    partner.send(8'h5A, 1'b0);
    rc("rx one", IDX_ISR, 8'h30, 8'h30);
    rc("rx data", IDX_DATA, 8'hFF, 8'h5A);
    rc("rx none", IDX_ISR, 8'h30, 8'h10);
  endtask : t_fifo

  task automatic t_levels();
    int lvl[4] = '{1, 4, 8, 14};
    for (int t = 0; t < 4; t++)
    begin
      wr(IDX_ISR, {2'(t), 6'h0F});
      for (int k = 0; k < lvl[t] - 1; k++) partner.send(8'(16 * t + k), 1'b0);
      rc("below level", IDX_ISR, 8'h20, 8'h00);
      partner.send(8'(16 * t + lvl[t] - 1), 1'b0);
      for (int k = 0; k < lvl[t]; k++)
      begin
        rc("held ready", IDX_ISR, 8'h20, 8'h20);
        rc("block data", IDX_DATA, 8'hFF, 8'(16 * t + k));
      end
      rc("drained", IDX_ISR, 8'h20, 8'h00);
    end
  endtask : t_levels

  // a lone byte under the threshold must still be reported once the line goes quiet
  task automatic t_timeout();
    wr(IDX_ISR, 8'h4F);
    partner.send(8'h77, 1'b0);
    rc("no timeout yet", IDX_ISR, 8'h20, 8'h00);
    repeat (2000) @(posedge aclk);
    rc("timeout ready", IDX_ISR, 8'h20, 8'h20);
    rc("timeout data", IDX_DATA, 8'hFF, 8'h77);
    rc("timeout clear", IDX_ISR, 8'h20, 8'h00);
  endtask : t_timeout

  // one byte sits in the shifter, so 17 writes fill the buffer
  task automatic t_txfull();
    wr(IDX_ISR, 8'h0F);
    for (int k = 0; k < 17; k++) wr(IDX_DATA, 8'(64 + k));
    rc("tx full", IDX_ISR, 8'h10, 8'h00);
    wr(IDX_IER, 8'h20);
    rc("flags inverted", IDX_ISR, 8'h30, 8'h30);
    wr(IDX_IER, 8'h00);
    tx_chk(8'h40);
    repeat (partner.bit_clks) @(posedge aclk);
    rc("tx one free", IDX_ISR, 8'h10, 8'h10);
    for (int k = 1; k < 17; k++) tx_chk(8'(64 + k));
  endtask : t_txfull

  task automatic t_rxerr();
    wr(IDX_ISR, 8'h06);
    partner.send(8'h66, 1'b1);
    rc("rx held", IDX_ISR, 8'h30, 8'h30);
    rc("parity err", IDX_LSR, 8'h0E, 8'h04);
    rc("rx byte", IDX_DATA, 8'hFF, 8'h66);
    rc("rx gone", IDX_ISR, 8'h30, 8'h10);
    chk("line errors", 8'(partner.bad_cnt), 8'h00);
  endtask : t_rxerr

  initial
  begin
    repeat (60000) @(posedge aclk);
    fails++;
    results();
  end

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    arvalid = 1'b0;
    awaddr  = 32'h0;
    wdata   = 32'h0;
    araddr  = 32'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_baud();
    t_fifo();
    t_levels();
    t_timeout();
    t_txfull();
    t_rxerr();
    results();
  end
endmodule : tb_top

//--- tb/ubr_line_partner.sv
`timescale 1ns/1ps
module ubr_line_partner (
  input  wire logic aclk,
  input  wire logic line_rx,
  output logic      line_tx
);
  int unsigned bit_clks = 32;
  int unsigned bad_cnt  = 0;
  logic [7:0]  rx_q[$];

  initial line_tx = 1'b1;

  // start, lsb first, even parity, stop
  task automatic send(input logic [7:0] b, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ^b ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_tx <= f[i];
      repeat (bit_clks) @(posedge aclk);
    end
  endtask : send

  // sample mid bit, flag bad frames
  always
  begin
    logic [9:0] s;
    @(negedge line_rx);
    repeat (bit_clks / 2) @(posedge aclk);
    if (line_rx !== 1'b0) bad_cnt++;
    for (int i = 0; i < 10; i++)
    begin
      repeat (bit_clks) @(posedge aclk);
      s[i] = line_rx;
    end
    if (s[9] !== 1'b1 || s[8] !== ^s[7:0]) bad_cnt++;
    rx_q.push_back(s[7:0]);
  end
endmodule : ubr_line_partner
